// File: core/descriptor_transfer_unit.sv
// interrupt-activated descriptor transfer engine
`timescale 1ns/1ps

module descriptor_transfer_unit #(
    parameter int unsigned SRC_N = xfer_pkg::SRC_COUNT
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // activation sources
    input  wire logic [SRC_N-1:0] source_request_i,
    input  wire logic [SRC_N-1:0] source_activation_enable_i,
    input  wire logic [31:0]      vector_base_i,
    output logic      [SRC_N-1:0] source_done_o,
    // cpu interrupt
    output logic                  cpu_irq_o,
    output logic      [7:0]       cpu_irq_vector_o,
    output logic                  busy_o,
    // memory bus master
    output logic                  mem_req_o,
    output logic                  mem_we_o,
    output logic      [31:0]      mem_addr_o,
    output logic      [31:0]      mem_wdata_o,
    output logic      [1:0]       mem_size_o,
    input  wire logic             mem_ack_i,
    input  wire logic [31:0]      mem_rdata_i
);

    typedef enum {
        ST_IDLE,
        ST_VEC_RD,
        ST_DESC_RD,
        ST_DATA_RD,
        ST_DATA_WR,
        ST_WRITEBACK,
        ST_DECIDE
    } phase_e;

    typedef struct packed {
        phase_e           phase;
        logic [2:0]       src;
        logic [31:0]      desc_addr;
        logic [1:0]       widx;
        logic [31:0]      mode;
        logic [31:0]      sa;
        logic [31:0]      da;
        logic [31:0]      sa0;
        logic [31:0]      da0;
        logic [31:0]      count;
        logic             mem_req;
        logic             mem_we;
        logic [31:0]      mem_addr;
        logic [31:0]      mem_wdata;
        logic [1:0]       mem_size;
        logic             cpu_irq;
        logic [7:0]       irq_vector;
        logic [SRC_N-1:0] done;
        logic             busy;
    } state_s;

    state_s           state_reg;
    state_s           state_next;
    logic [SRC_N-1:0] pending;
    logic             bus_done;

    word_stream_if #(.WIDTH(32)) rd_stream ();
    word_stream_if #(.WIDTH(32)) wr_stream ();

    // ======================================================
    // helpers

    // next address for one unit
    function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] am,
                                              input logic [1:0] sz);
        logic [31:0] inc;
        inc = 32'h0000_0001 << sz;
        if (am == xfer_pkg::AMODE_INC) begin
            return a + inc;
        end else if (am == xfer_pkg::AMODE_DEC) begin
            return a - inc;
        end
        return a;
    endfunction

    // lowest index wins: table order is priority order
    function automatic logic [2:0] first_set(input logic [SRC_N-1:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = SRC_N - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = i[2:0];
            end
        end
        return idx;
    endfunction

    // unit data in the low lanes, the rest cleared
    function automatic logic [31:0] unit_mask(input logic [31:0] d, input logic [1:0] sz);
        if (sz == xfer_pkg::SIZE_BYTE) begin
            return {24'h00_0000, d[7:0]};
        end else if (sz == xfer_pkg::SIZE_WORD) begin
            return {16'h0000, d[15:0]};
        end
        return d;
    endfunction

    // ======================================================
    // data buffer: reads fill it, writes drain it
    two_entry_buffer #(
        .WIDTH (32)
    ) u_buffer (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .fill  (rd_stream.consumer),
        .drain (wr_stream.producer)
    );

    assign bus_done        = state_reg.mem_req && mem_ack_i;
    assign rd_stream.valid = (state_reg.phase == ST_DATA_RD) && bus_done;
    assign rd_stream.data  = unit_mask(mem_rdata_i, state_reg.mem_size);
    assign wr_stream.ready = (state_reg.phase == ST_DATA_WR) && bus_done;

    // sources that may start: a disabled source is ignored and raises no cpu interrupt
    assign pending = source_request_i & source_activation_enable_i
                   & xfer_pkg::SRC_ACTIVATES[SRC_N-1:0]
                   & ~state_reg.done;

    // ======================================================
    // sequencer
    always_comb begin
        logic [1:0]  sz;
        logic [1:0]  xm;
        logic        area;
        logic        finish;
        logic        zero;
        sz         = state_reg.mode[xfer_pkg::F_SIZE +: 2];
        xm         = state_reg.mode[xfer_pkg::F_XFER_MODE +: 2];
        area       = state_reg.mode[xfer_pkg::F_AREA_SEL];
        finish     = 1'b0;
        zero       = 1'b0;
        state_next = state_reg;
        state_next.cpu_irq = 1'b0;
        state_next.done    = '0;
        // a request stands until its acknowledge
        if (bus_done) begin
            state_next.mem_req = 1'b0;
        end
        unique case (state_reg.phase)
            ST_IDLE: begin
                if (|pending) begin
                    state_next.src       = first_set(pending);
                    state_next.phase     = ST_VEC_RD;
                    state_next.mem_req   = 1'b1;
                    state_next.mem_we    = 1'b0;
                    state_next.mem_size  = xfer_pkg::SIZE_LONG;
                    state_next.mem_addr  = vector_base_i + xfer_pkg::VEC_TABLE_BASE
                                         + {22'h00_0000, xfer_pkg::SRC_VECTOR[first_set(pending)], 2'h0};
                end
            end
            ST_VEC_RD: begin
                if (bus_done) begin
                    state_next.desc_addr = mem_rdata_i;
                    state_next.widx      = xfer_pkg::WORD_MODE;
                    state_next.phase     = ST_DESC_RD;
                    state_next.mem_req   = 1'b1;
                    state_next.mem_addr  = mem_rdata_i;
                end
            end
            ST_DESC_RD: begin
                // descriptor first, data after it
                if (bus_done) begin
                    unique case (state_reg.widx)
                        xfer_pkg::WORD_MODE:  state_next.mode = mem_rdata_i;
                        xfer_pkg::WORD_SRC: begin
                            state_next.sa  = mem_rdata_i;
                            state_next.sa0 = mem_rdata_i;
                        end
                        xfer_pkg::WORD_DST: begin
                            state_next.da  = mem_rdata_i;
                            state_next.da0 = mem_rdata_i;
                        end
                        xfer_pkg::WORD_COUNT: state_next.count = mem_rdata_i;
                    endcase
                    if (state_reg.widx == xfer_pkg::WORD_COUNT) begin
                        state_next.phase = ST_DATA_RD;
                    end else begin
                        state_next.widx     = state_reg.widx + 2'h1;
                        state_next.mem_req  = 1'b1;
                        state_next.mem_addr = state_reg.desc_addr + {28'h000_0000, state_reg.widx + 2'h1, 2'h0};
                    end
                end
            end
            ST_DATA_RD: begin
                // read only with room in the buffer, so no word is lost
                if (!state_reg.mem_req && rd_stream.ready) begin
                    state_next.mem_req  = 1'b1;
                    state_next.mem_we   = 1'b0;
                    state_next.mem_size = sz;
                    state_next.mem_addr = state_reg.sa;
                end
                if (bus_done) begin
                    state_next.phase = ST_DATA_WR;
                end
            end
            ST_DATA_WR: begin
                if (!state_reg.mem_req && wr_stream.valid) begin
                    state_next.mem_req   = 1'b1;
                    state_next.mem_we    = 1'b1;
                    state_next.mem_size  = sz;
                    state_next.mem_addr  = state_reg.da;
                    state_next.mem_wdata = wr_stream.data;
                end
                if (bus_done) begin
                    // both addresses step on their own modes
                    state_next.sa = step_addr(state_reg.sa, state_reg.mode[xfer_pkg::F_SRC_MODE +: 2], sz);
                    state_next.da = step_addr(state_reg.da, state_reg.mode[xfer_pkg::F_DST_MODE +: 2], sz);
                    unique case (xm)
                        xfer_pkg::XMODE_REPEAT: begin
                            finish = 1'b1;
                            if (state_reg.count[23:16] == 8'h01) begin
                                state_next.count[23:16] = state_reg.count[31:24];
                                if (area) begin
                                    state_next.sa = state_reg.sa0;
                                end else begin
                                    state_next.da = state_reg.da0;
                                end
                            end else begin
                                state_next.count[23:16] = state_reg.count[23:16] - 8'h01;
                            end
                        end
                        xfer_pkg::XMODE_BLOCK: begin
                            if (state_reg.count[23:16] == 8'h01) begin
                                // block end: restore size and block-area address
                                finish = 1'b1;
                                state_next.count[23:16] = state_reg.count[31:24];
                                state_next.count[15:0]  = state_reg.count[15:0] - 16'h0001;
                                if (area) begin
                                    state_next.sa = state_reg.sa0;
                                end else begin
                                    state_next.da = state_reg.da0;
                                end
                            end else begin
                                // size 0 means 256: wraps through ff
                                state_next.count[23:16] = state_reg.count[23:16] - 8'h01;
                                state_next.phase        = ST_DATA_RD;
                            end
                        end
                        default: begin
                            finish = 1'b1;
                            state_next.count[31:16] = state_reg.count[31:16] - 16'h0001;
                        end
                    endcase
                    if (finish) begin
                        state_next.phase     = ST_WRITEBACK;
                        state_next.widx      = xfer_pkg::WORD_SRC;
                        state_next.mem_req   = 1'b1;
                        state_next.mem_we    = 1'b1;
                        state_next.mem_size  = xfer_pkg::SIZE_LONG;
                        state_next.mem_addr  = state_reg.desc_addr + {28'h000_0000, xfer_pkg::WORD_SRC, 2'h0};
                        state_next.mem_wdata = state_next.sa;
                    end
                end
            end
            ST_WRITEBACK: begin
                // addresses and counts go back, mode word is unchanged
                if (bus_done) begin
                    if (state_reg.widx == xfer_pkg::WORD_COUNT) begin
                        state_next.phase = ST_DECIDE;
                    end else begin
                        state_next.widx      = state_reg.widx + 2'h1;
                        state_next.mem_req   = 1'b1;
                        state_next.mem_addr  = state_reg.desc_addr + {28'h000_0000, state_reg.widx + 2'h1, 2'h0};
                        state_next.mem_wdata = (state_reg.widx == xfer_pkg::WORD_SRC) ? state_reg.da
                                                                                      : state_reg.count;
                    end
                end
            end
            ST_DECIDE: begin
                // counter already decremented; pick the one this mode tests
                unique case (xm)
                    xfer_pkg::XMODE_REPEAT: zero = (state_reg.count[23:16] == 8'h00);
                    xfer_pkg::XMODE_BLOCK:  zero = (state_reg.count[15:0] == 16'h0000);
                    default:                zero = (state_reg.count[31:16] == 16'h0000);
                endcase
                if (state_reg.mode[xfer_pkg::F_CHAIN_EN]
                    && (!state_reg.mode[xfer_pkg::F_CHAIN_ZERO] || zero)) begin
                    // next descriptor decides for itself
                    state_next.desc_addr = state_reg.desc_addr + xfer_pkg::DESC_STRIDE;
                    state_next.widx      = xfer_pkg::WORD_MODE;
                    state_next.phase     = ST_DESC_RD;
                    state_next.mem_req   = 1'b1;
                    state_next.mem_we    = 1'b0;
                    state_next.mem_size  = xfer_pkg::SIZE_LONG;
                    state_next.mem_addr  = state_reg.desc_addr + xfer_pkg::DESC_STRIDE;
                end else begin
                    // last descriptor: only its select bit raises the cpu
                    state_next.cpu_irq         = state_reg.mode[xfer_pkg::F_IRQ_SEL];
                    state_next.irq_vector      = xfer_pkg::SRC_VECTOR[state_reg.src];
                    state_next.done[state_reg.src] = 1'b1;
                    state_next.phase           = ST_IDLE;
                end
            end
        endcase
        // kept in a flop so busy_o leaves no decode glitch at the pin
        state_next.busy = (state_next.phase != ST_IDLE);
    end

    // ======================================================
    // state register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg            <= '0;
            state_reg.phase      <= ST_IDLE;
            state_reg.irq_vector <= xfer_pkg::RST_VECTOR;
            state_reg.mem_addr   <= xfer_pkg::RST_WORD;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign source_done_o    = state_reg.done;
    assign cpu_irq_o        = state_reg.cpu_irq;
    assign cpu_irq_vector_o = state_reg.irq_vector;
    assign busy_o           = state_reg.busy;
    assign mem_req_o        = state_reg.mem_req;
    assign mem_we_o         = state_reg.mem_we;
    assign mem_addr_o       = state_reg.mem_addr;
    assign mem_wdata_o      = state_reg.mem_wdata;
    assign mem_size_o       = state_reg.mem_size;

endmodule

// File: core/two_entry_buffer.sv
// two-entry valid/ready buffer in the data path
`timescale 1ns/1ps
module two_entry_buffer #(
    parameter int unsigned WIDTH = 32
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // streams
    word_stream_if.consumer   fill,
    word_stream_if.producer   drain
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] slot;
        logic                  head;
        logic [1:0]            level;
    } state_s;

    state_s state_reg;
    state_s state_next;
    logic   push;
    logic   pop;

    // ======================================================
    // handshakes: full refuses, empty shows nothing
    assign fill.ready  = (state_reg.level != 2'h2);
    assign drain.valid = (state_reg.level != 2'h0);
    assign drain.data  = state_reg.slot[state_reg.head];
    assign push        = fill.valid && fill.ready;
    assign pop         = drain.valid && drain.ready;

    // next state
    always_comb begin
        state_next = state_reg;
        if (push) begin
            state_next.slot[state_reg.head ^ state_reg.level[0]] = fill.data;
        end
        if (pop) begin
            state_next.head = ~state_reg.head;
        end
        state_next.level = state_reg.level + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule

// File: core/word_stream_if.sv
// valid/ready word stream between the transfer core and its buffer
`timescale 1ns/1ps
interface word_stream_if #(
    parameter int unsigned WIDTH = 32
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport producer (output valid, output data, input  ready);
    modport consumer (input  valid, input  data, output ready);
endinterface

// File: core/xfer_pkg.sv
// shared constants of the descriptor transfer unit
package xfer_pkg;

    // ==========================================================
    // activation sources, highest priority first
    localparam int unsigned SRC_COUNT = 7;
    localparam logic [7:0] SRC_VECTOR [SRC_COUNT] = '{
        8'hb6, 8'hb7, 8'hb8, 8'hb9, 8'hba, 8'hbc, 8'hbd
    };
    // 184 and 185 reserved, 186 (timer10_overflow_irq) never activates
    localparam logic [SRC_COUNT-1:0] SRC_ACTIVATES = 7'b110_0011;
    // vector table offset = base + 4 * vector number
    localparam logic [31:0] VEC_TABLE_BASE = 32'h0000_0400;

    // ==========================================================
    // descriptor layout: four words, written back from word 1
    localparam logic [31:0] DESC_STRIDE   = 32'h0000_0010;
    localparam logic [1:0]  WORD_MODE     = 2'h0;
    localparam logic [1:0]  WORD_SRC      = 2'h1;
    localparam logic [1:0]  WORD_DST      = 2'h2;
    localparam logic [1:0]  WORD_COUNT    = 2'h3;

    // mode word fields
    localparam int unsigned F_SIZE        = 0;  // two bits
    localparam int unsigned F_SRC_MODE    = 2;  // two bits
    localparam int unsigned F_DST_MODE    = 4;  // two bits
    localparam int unsigned F_XFER_MODE   = 6;  // two bits
    localparam int unsigned F_AREA_SEL    = 8;
    localparam int unsigned F_CHAIN_EN    = 9;
    localparam int unsigned F_CHAIN_ZERO  = 10;
    localparam int unsigned F_IRQ_SEL     = 11;

    // encodings
    localparam logic [1:0] SIZE_BYTE      = 2'h0;
    localparam logic [1:0] SIZE_WORD      = 2'h1;
    localparam logic [1:0] SIZE_LONG      = 2'h2;
    localparam logic [1:0] AMODE_INC      = 2'h2;
    localparam logic [1:0] AMODE_DEC      = 2'h3;
    localparam logic [1:0] XMODE_NORMAL   = 2'h0;
    localparam logic [1:0] XMODE_REPEAT   = 2'h1;
    localparam logic [1:0] XMODE_BLOCK    = 2'h2;

    // reset values
    localparam logic [31:0] RST_WORD      = 32'h0000_0000;
    localparam logic [7:0]  RST_VECTOR    = 8'h00;

endpackage

// File: verif/descriptor_transfer_unit_bench.sv
// self-checking bench of the descriptor transfer unit
`timescale 1ns/1ps
module descriptor_transfer_unit_bench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        slow = 1'b0;
    logic [6:0]  req = 7'h0;
    logic [6:0]  enable = 7'b111_0011;
    logic [6:0]  done;
    logic        mem_req, mem_we, mem_ack, irq, busy;
    logic [31:0] mem_addr, mem_wdata, mem_rdata;
    logic [1:0]  mem_size;
    logic [7:0]  vec;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          i;
    // memory image and results as {word index, value}
    localparam logic [41:0] IMAGE [27] = '{42'h1b6_00000100, 42'h1bd_00000140, 42'h1bc_00000180,
        42'h040_0000082a, 42'h041_00000200, 42'h042_00000300, 42'h043_00020000, 42'h080_12345678,
        42'h050_000006aa, 42'h051_00000210, 42'h052_00000310, 42'h053_02020001, 42'h084_a1a10001,
        42'h085_a1a10002, 42'h054_0000080e, 42'h055_00000228, 42'h056_00000320, 42'h057_00050000,
        42'h08a_c3c30003, 42'h060_00000769, 42'h061_00000240, 42'h062_00000340, 42'h063_03010000,
        42'h090_d4d40004, 42'h0c0_00000000, 42'h0c4_00000000, 42'h0d0_00000000};
    localparam logic [41:0] RESULT [17] = '{42'h0c0_12345678, 42'h041_00000204, 42'h042_00000304,
        42'h043_00010000, 42'h0c4_a1a10001, 42'h0c5_a1a10002, 42'h051_00000218, 42'h052_00000310,
        42'h053_02020000, 42'h0c8_c3c30003, 42'h055_00000224, 42'h056_00000320, 42'h057_00040000,
        42'h0d0_00000004, 42'h061_00000240, 42'h062_00000342, 42'h063_03030000};
    descriptor_transfer_unit i_dut (.clk_i(clk_i), .rst_i(rst_i), .source_request_i(req),
        .source_activation_enable_i(enable), .vector_base_i(32'h0), .source_done_o(done),
        .cpu_irq_o(irq), .cpu_irq_vector_o(vec), .busy_o(busy), .mem_req_o(mem_req), .mem_we_o(mem_we),
        .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_size_o(mem_size),
        .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata));
    xfer_mem_model i_mem (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .mem_req_i(mem_req),
        .mem_we_i(mem_we), .mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata), .mem_ack_o(mem_ack),
        .mem_rdata_o(mem_rdata));
    // ==========
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // hold the request until the done pulse, then check who finished and the irq
    task automatic run(input logic [6:0] r, input logic s, input logic [6:0] d, input logic q,
                       input logic [7:0] v);
        req = r;
        slow = s;
        while (done === 7'h0) @(negedge clk_i);
        check(32'(done), 32'(d));
        check(32'(irq), 32'(q));
        if (q) check(32'(vec), 32'(v));
        req = 7'h0;
        @(negedge clk_i);
    endtask
    task automatic wrap_up();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ==========
    // clock, timeout, sequence
    always #2.5 clk_i = ~clk_i;
    // generous ceiling; three activations need a few hundred cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        foreach (IMAGE[k]) i_mem.mem[IMAGE[k][41:32]] = IMAGE[k][31:0];
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
        @(negedge clk_i);
        run(7'h01, 1'b0, 7'h01, 1'b1, 8'hb6);
        run(7'h40, 1'b1, 7'h40, 1'b1, 8'hbd);
        run(7'h30, 1'b0, 7'h20, 1'b0, 8'h00);
        // a source with its enable cleared must leave the engine idle
        enable[1] = 1'b0;
        req = 7'h02;
        repeat (20) @(negedge clk_i);
        check(32'({busy, done, irq}), 32'h0);
        req = 7'h00;
        for (i = 0; i < 17; i++) check(i_mem.mem[RESULT[i][41:32]], RESULT[i][31:0]);
        wrap_up();
    end
endmodule

// File: verif/descriptor_transfer_unit_props.sv
// port checks of the descriptor transfer unit
`timescale 1ns/1ps
module descriptor_transfer_unit_props #(
    parameter int unsigned SRC_N = xfer_pkg::SRC_COUNT
) (
    // clock and reset
    input wire logic             clk_i,
    input wire logic             rst_i,
    // watched ports
    input wire logic [31:0]      vector_base_i,
    input wire logic [SRC_N-1:0] source_done_o,
    input wire logic             cpu_irq_o,
    input wire logic [7:0]       cpu_irq_vector_o,
    input wire logic             busy_o,
    input wire logic             mem_req_o,
    input wire logic             mem_we_o,
    input wire logic [31:0]      mem_addr_o,
    input wire logic [31:0]      mem_wdata_o,
    input wire logic [1:0]       mem_size_o,
    input wire logic             mem_ack_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========
    // properties
    property p_no_timer10; !(|source_done_o[4:2]); endproperty
    property p_vec_fetch; $rose(busy_o) |-> ##[0:2] (mem_req_o && !mem_we_o
        && (mem_addr_o - vector_base_i) inside {32'h6d8, 32'h6dc, 32'h6f0, 32'h6f4}); endproperty
    property p_done_idle; |source_done_o |-> !busy_o && $past(busy_o); endproperty
    property p_done_pulse; |source_done_o |=> !(|source_done_o); endproperty
    property p_irq_done; cpu_irq_o |-> |source_done_o; endproperty
    property p_irq_vec; cpu_irq_o |-> cpu_irq_vector_o == (source_done_o[0] ? 8'hb6 :
        source_done_o[1] ? 8'hb7 : source_done_o[5] ? 8'hbc : 8'hbd); endproperty
    property p_req_hold; mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
        && $stable(mem_we_o) && $stable(mem_wdata_o) && $stable(mem_size_o); endproperty
    property p_busy_bound; $rose(busy_o) |-> ##[1:1000] !busy_o; endproperty
    a_no_timer10: assert property (p_no_timer10) else $error("blocked source finished");
    a_vec_fetch: assert property (p_vec_fetch) else $error("no vector read");
    a_done_idle: assert property (p_done_idle) else $error("done not at idle");
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");
    a_irq_done: assert property (p_irq_done) else $error("irq without done");
    a_irq_vec: assert property (p_irq_vec) else $error("irq vector wrong");
    a_req_hold: assert property (p_req_hold) else $error("request moved");
    a_busy_bound: assert property (p_busy_bound) else $error("activation hangs");
    c_irq: cover property (cpu_irq_o);
    c_done_last: cover property (source_done_o[6]);
    c_write: cover property (mem_req_o && mem_we_o && mem_ack_i);
endmodule
bind descriptor_transfer_unit descriptor_transfer_unit_props #(.SRC_N(SRC_N)) i_props (
    .clk_i(clk_i), .rst_i(rst_i), .vector_base_i(vector_base_i), .source_done_o(source_done_o),
    .cpu_irq_o(cpu_irq_o), .cpu_irq_vector_o(cpu_irq_vector_o), .busy_o(busy_o),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_size_o(mem_size_o), .mem_ack_i(mem_ack_i)
);

// File: verif/xfer_mem_model.sv
// bus partner model: word memory with prompt or slow answers
`timescale 1ns/1ps
module xfer_mem_model (
    // clock, reset and pacing
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        slow_i,
    // bus from the engine
    input  wire logic        mem_req_i,
    input  wire logic        mem_we_i,
    input  wire logic [31:0] mem_addr_i,
    input  wire logic [31:0] mem_wdata_i,
    output logic             mem_ack_o,
    output logic      [31:0] mem_rdata_o
);
    logic [31:0] mem [1024];
    logic [2:0]  wait_reg;
    // ==========
    // answer
    // ack lasts one cycle; read data toggles outside ack so a late sample shows
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_ack_o   <= 1'b0;
            wait_reg    <= 3'h0;
            mem_rdata_o <= 32'h0;
        end else if (mem_ack_o || !mem_req_i || wait_reg < {1'b0, slow_i, slow_i}) begin
            mem_ack_o   <= 1'b0;
            wait_reg    <= (mem_req_i && !mem_ack_o) ? wait_reg + 3'h1 : 3'h0;
            mem_rdata_o <= ~mem_rdata_o;
        end else begin
            mem_ack_o   <= 1'b1;
            mem_rdata_o <= mem[mem_addr_i[11:2]];
            if (mem_we_i) begin
                mem[mem_addr_i[11:2]] <= mem_wdata_i;
            end
        end
    end
endmodule
